// ---- rtl/sao_pkg.sv ----
`default_nettype none
package sao_pkg;
  // ***********************************************
  // Opcode layout
  // ***********************************************
  localparam logic [6:0] SAO_OPCODE_HI = 7'h34;
  localparam int SAO_A_BIT = 8;
  localparam int SAO_OP_MSB = 15;
  localparam int SAO_OP_LSB = 9;
  localparam logic [7:0] SAO_ALL_ONES = 8'hff;
  localparam logic [7:0] SAO_INDEXED_MAX = 8'h5f;
  localparam logic [7:0] SAO_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] SAO_ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] SAO_BSR_RESET = 4'h0;
  localparam logic [7:0] SAO_FSR2_RESET = 8'h00;
  localparam int SAO_ADDR_W = 12;
  localparam int SAO_BANK_W = 4;
  typedef enum logic [1:0] {
    SAO_Q1 = 2'b00,
    SAO_Q2 = 2'b01,
    SAO_Q3 = 2'b10,
    SAO_Q4 = 2'b11
  } sao_phase_type;
endpackage
`default_nettype wire

// ---- rtl/sao_addr_gen.sv ----
`default_nettype none
module sao_addr_gen
  import sao_pkg::*;
(
  input wire logic [7:0] field,
  input wire logic access_sel,
  input wire logic ext_set_en,
  input wire logic [sao_pkg::SAO_BANK_W-1:0] bank_sel,
  input wire logic [sao_pkg::SAO_ADDR_W-1:0] index_base,
  output logic [sao_pkg::SAO_ADDR_W-1:0] addr
);
  wire indexed = ext_set_en && !access_sel && (field <= SAO_INDEXED_MAX);
  wire [3:0] acc_bank = (field < SAO_ACCESS_SPLIT) ? 4'h0 : SAO_ACCESS_HI_BANK;
  wire [11:0] acc_addr = {acc_bank, field};
  wire [11:0] bank_addr = {bank_sel, field};
  wire [11:0] idx_addr = index_base + {4'h0, field};
  assign addr = indexed ? idx_addr : (access_sel ? bank_addr : acc_addr);
endmodule
`default_nettype wire

// ---- rtl/sao_set_all_ones.sv ----
`default_nettype none
module sao_set_all_ones
  import sao_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic ext_set_en,
  input wire logic [sao_pkg::SAO_BANK_W-1:0] bank_sel,
  input wire logic [sao_pkg::SAO_ADDR_W-1:0] index_base,
  output logic rd_en,
  output logic [sao_pkg::SAO_ADDR_W-1:0] mem_addr,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic busy,
  output logic status_we
);
  // ***********************************************
  // Decode
  // ***********************************************
  sao_phase_type phase_q, phase_d;
  logic active_q;
  logic [11:0] addr_calc;
  wire hit = instr_valid && (instr[SAO_OP_MSB:SAO_OP_LSB] == SAO_OPCODE_HI);
  wire start = hit && !active_q && (phase_q == SAO_Q1);
  sao_addr_gen u_addr (
    .field(instr[7:0]),
    .access_sel(instr[SAO_A_BIT]),
    .ext_set_en(ext_set_en),
    .bank_sel(bank_sel),
    .index_base(index_base),
    .addr(addr_calc)
  );
  // ***********************************************
  // Phase sequence
  // ***********************************************
  always_comb begin
    unique case (phase_q)
      SAO_Q1: phase_d = start ? SAO_Q2 : SAO_Q1;
      SAO_Q2: phase_d = SAO_Q3;
      SAO_Q3: phase_d = SAO_Q4;
      SAO_Q4: phase_d = SAO_Q1;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_q <= SAO_Q1;
      active_q <= 1'b0;
      rd_en <= 1'b0;
      mem_addr <= 12'h000;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      busy <= 1'b0;
      status_we <= 1'b0;
    end else if (clk_en) begin
      phase_q <= phase_d;
      active_q <= (phase_d != SAO_Q1);
      busy <= (phase_d != SAO_Q1);
      // Address is latched once so a new word during busy cannot redirect the write
      if (start) begin
        mem_addr <= addr_calc;
      end
      // Dummy read keeps the read-modify-write timing of other byte ops
      rd_en <= (phase_d == SAO_Q2);
      wr_en <= (phase_d == SAO_Q4);
      wr_data <= SAO_ALL_ONES;
      status_we <= 1'b0;
    end
  end
  // ***********************************************
  // Checks
  // ***********************************************
  a_write_all_ones: assert property (@(posedge clk_sys) disable iff (reset)
    wr_en |-> wr_data == 8'hff) else $error("write data not all ones");
  a_flags_untouched: assert property (@(posedge clk_sys) disable iff (reset)
    !status_we) else $error("status written");
  a_four_phase: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && start) ##1 clk_en [*2] |=> wr_en) else $error("write not in fourth phase");
  a_read_before: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(wr_en) |-> $past(rd_en, 2) || !$past(clk_en)) else $error("no read before write");
  a_bank_addr: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && start && instr[8]) |=> mem_addr == {$past(bank_sel), $past(instr[7:0])})
    else $error("banked address wrong");
  a_access_addr: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && start && !instr[8] && !ext_set_en) |=> mem_addr[7:0] == $past(instr[7:0])
    && (mem_addr[11:8] == 4'h0 || mem_addr[11:8] == 4'hf)) else $error("access address wrong");
  a_indexed_addr: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && start && !instr[8] && ext_set_en && instr[7:0] <= 8'h5f)
    |=> mem_addr == $past(index_base) + {4'h0, $past(instr[7:0])})
    else $error("indexed address wrong");
  a_single_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr_en && clk_en |=> !wr_en) else $error("write longer than one phase");
  a_freeze_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !clk_en |=> $stable(rd_en) && $stable(wr_en) && $stable(mem_addr) && $stable(busy))
    else $error("state moved while clock enable low");
  a_busy_ignores: assert property (@(posedge clk_sys) disable iff (reset)
    (busy && clk_en) |=> $stable(mem_addr)) else $error("address changed while busy");
endmodule
`default_nettype wire

// ---- tb/tb_sao_set_all_ones.sv ----
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_sao_set_all_ones;
  timeunit 1ns;
  timeprecision 1ps;
  import sao_pkg::*;
  logic clk_sys = 0, reset = 1, clk_en = 1, instr_valid = 0, ext_set_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] bank_sel = 4'h3;
  logic [11:0] index_base = 12'h200;
  logic rd_en, wr_en, busy, status_we;
  logic [11:0] mem_addr;
  logic [7:0] wr_data;
  int num_errors = 0, check_count = 0;
  sao_set_all_ones dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .instr(instr),
    .instr_valid(instr_valid), .ext_set_en(ext_set_en), .bank_sel(bank_sel),
    .index_base(index_base), .rd_en(rd_en), .mem_addr(mem_addr), .wr_en(wr_en),
    .wr_data(wr_data), .busy(busy), .status_we(status_we));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  // *****************************
  // One instruction, four phases
  // *****************************
  task automatic run(input logic [15:0] w, input logic x, input logic [11:0] ea);
    instr = w;
    instr_valid = 1;
    ext_set_en = x;
    step();
    instr_valid = 0;
    instr = ~w;
    `CHK("rd_en", 1'b1, rd_en)
    `CHK("busy", 1'b1, busy)
    `CHK("mem_addr", ea, mem_addr)
    step();
    `CHK("rd_en", 1'b0, rd_en)
    step();
    `CHK("wr_en", 1'b1, wr_en)
    `CHK("wr_data", SAO_ALL_ONES, wr_data)
    step();
    `CHK("busy", 1'b0, busy)
    `CHK("wr_en", 1'b0, wr_en)
    `CHK("status_we", 1'b0, status_we)
  endtask
  // Clock enable low freezes the cycle; a word arriving while busy is ignored
  task automatic freeze();
    instr = 16'h6912;
    instr_valid = 1;
    ext_set_en = 0;
    step();
    instr = 16'h6812;
    clk_en = 0;
    step();
    `CHK("rd_en", 1'b1, rd_en)
    `CHK("mem_addr", 12'h312, mem_addr)
    clk_en = 1;
    step();
    `CHK("rd_en", 1'b0, rd_en)
    `CHK("mem_addr", 12'h312, mem_addr)
    step();
    `CHK("wr_en", 1'b1, wr_en)
    instr_valid = 0;
    step();
    `CHK("wr_en", 1'b0, wr_en)
    `CHK("busy", 1'b0, busy)
  endtask
  // Neighbouring opcode must not start a cycle
  task automatic refuse();
    instr = 16'h6a12;
    instr_valid = 1;
    repeat (4) begin
      step();
      `CHK("rd_en", 1'b0, rd_en)
    end
    instr_valid = 0;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 0;
    `CHK("busy", 1'b0, busy)
    // Back to back, both sides of the access split and of the indexed limit
    run(16'h6912, 0, 12'h312);
    run(16'h6812, 0, 12'h012);
    run(16'h68a0, 0, 12'hfa0);
    run(16'h6812, 1, 12'h212);
    run(16'h685f, 1, 12'h25f);
    run(16'h6860, 1, 12'hf60);
    run(16'h6900, 1, 12'h300);
    refuse();
    freeze();
    stop_test();
  end
endmodule
`default_nettype wire
